// File: pkg/cic_regs.svh
// Purpose: register offsets, field positions and reset values of the interrupt controller
// Assumes: word offsets on a plain register port, 32-bit data
// Notes: trigger field is two bits per source, split over two registers
`ifndef CIC_REGS_SVH
`define CIC_REGS_SVH

`define CIC_ADDR_W 8
// source tier
`define CIC_SOURCE_RAW_VECTOR 8'h00
`define CIC_SOURCE_NONLATCH_SELECT 8'h01
`define CIC_SOURCE_DETECT_MODE_LO 8'h02
`define CIC_SOURCE_DETECT_MODE_HI 8'h03
`define CIC_SOURCE_EVENT_INJECT 8'h04
`define CIC_SOURCE_EVENT_LOG 8'h05
`define CIC_SOURCE_ENABLE_VECTOR 8'h06
`define CIC_SOURCE_ENABLE_CLEAR 8'h07
`define CIC_SOURCE_ENABLE_SET 8'h08
`define CIC_SOURCE_PENDING_IDENTITY 8'h09
// destination tier, four consecutive words each
`define CIC_DESTINATION_SOURCE_MASK 8'h10
`define CIC_DESTINATION_PENDING_IDENTITY 8'h14
// module tier
`define CIC_MODULE_INPUT_POLARITY 8'h20
`define CIC_MODULE_RAW_VECTOR 8'h21
`define CIC_MODULE_NONLATCH_SELECT 8'h22
`define CIC_MODULE_DETECT_MODE_LO 8'h23
`define CIC_MODULE_DETECT_MODE_HI 8'h24
`define CIC_MODULE_EVENT_LOG 8'h25
`define CIC_MODULE_ENABLE_VECTOR 8'h26
`define CIC_MODULE_PENDING_IDENTITY 8'h27
// external pins
`define CIC_EXT_INPUT_POLARITY 8'h30
`define CIC_EXT_OUTPUT_POLARITY 8'h31
`define CIC_EXT_OUTPUT_DRIVE_MODE 8'h32

// source bit positions
`define CIC_BIT_PORT_MODULE_AGGREGATE 0
`define CIC_BIT_PIN_SOURCE_ZERO 1
`define CIC_BIT_PIN_SOURCE_ONE 2
`define CIC_BIT_TIMING_PLL_EVENT 26

// reset values
`define CIC_RST_ZERO 32'h0000_0000
`define CIC_RST_EXT_POL 2'h3

`endif

// File: pkg/cic_pkg.sv
// Purpose: types shared by the interrupt controller
// Assumes: nothing beyond the regs header
// Notes: detect modes follow the two-bit trigger encoding
package cic_pkg;
    typedef enum logic [1:0] {
        CIC_LEVEL = 2'h0,
        CIC_ANY_EDGE = 2'h1,
        CIC_FALL_EDGE = 2'h2,
        CIC_RISE_EDGE = 2'h3
    } cic_mode_e;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } cic_req_s;
endpackage

// File: src/cic_ctrl.sv
// Purpose: interrupt controller with 27 sources, port-module tier and four destinations
// Assumes: all inputs synchronous to core_clk; internal events active high
// Notes: source events are caught one cycle after the input; outputs are registered
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cic_regs.svh"

module cic_ctrl
    import cic_pkg::*;
#(
    parameter int MODULES = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // interrupt inputs: bits 3..26 of the source vector, bits 0..2 unused
    input wire logic [26:0] periph_irq,
    input wire logic [MODULES-1:0] port_module_irq,
    input wire logic [1:0] ext_irq_in,
    // destinations
    output logic [1:0] cpu_irq,
    output logic [1:0] ext_irq_out,
    output logic [1:0] ext_irq_oe
);
    localparam int NSRC = 27;

    cic_req_s req;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // software state
    logic [NSRC-1:0] src_nonlatch_reg, src_mode_lo_reg, src_mode_hi_reg, src_enable_reg;
    logic [NSRC-1:0] src_log_reg, src_prev_reg;
    logic [NSRC-1:0] dst_mask_reg [4];
    logic [MODULES-1:0] mod_pol_reg, mod_nonlatch_reg, mod_mode_lo_reg, mod_mode_hi_reg;
    logic [MODULES-1:0] mod_enable_reg, mod_log_reg, mod_prev_reg;
    logic [1:0] ext_in_pol_reg, ext_out_pol_reg, ext_drive_reg;

    // write decode helpers
    logic wr_src_nonlatch, wr_src_lo, wr_src_hi, wr_src_inject, wr_src_log;
    logic wr_en_vec, wr_en_clr, wr_en_set;
    assign wr_src_nonlatch = req.wr && req.addr == `CIC_SOURCE_NONLATCH_SELECT;
    assign wr_src_lo = req.wr && req.addr == `CIC_SOURCE_DETECT_MODE_LO;
    assign wr_src_hi = req.wr && req.addr == `CIC_SOURCE_DETECT_MODE_HI;
    assign wr_src_inject = req.wr && req.addr == `CIC_SOURCE_EVENT_INJECT;
    assign wr_src_log = req.wr && req.addr == `CIC_SOURCE_EVENT_LOG;
    assign wr_en_vec = req.wr && req.addr == `CIC_SOURCE_ENABLE_VECTOR;
    assign wr_en_clr = req.wr && req.addr == `CIC_SOURCE_ENABLE_CLEAR;
    assign wr_en_set = req.wr && req.addr == `CIC_SOURCE_ENABLE_SET;

    // event detection shared by both tiers
    function automatic logic detect(input logic cur, input logic prev,
                                    input logic lo, input logic hi);
        logic [1:0] m;
        m = {hi, lo};
        case (m)
            CIC_LEVEL: detect = cur;
            CIC_ANY_EDGE: detect = cur ^ prev;
            CIC_FALL_EDGE: detect = prev & ~cur;
            CIC_RISE_EDGE: detect = cur & ~prev;
            default: detect = 1'b0;
        endcase
    endfunction

    // module tier: polarity first, then detection and log
    logic [MODULES-1:0] mod_raw, mod_evt, mod_pending, mod_ident;
    assign mod_raw = port_module_irq ^ mod_pol_reg;
    always_comb begin
        for (int i = 0; i < MODULES; i++) begin
            mod_evt[i] = detect(mod_raw[i], mod_prev_reg[i], mod_mode_lo_reg[i],
                                mod_mode_hi_reg[i]);
        end
    end
    assign mod_pending = (mod_nonlatch_reg & mod_raw) | (~mod_nonlatch_reg & mod_log_reg);
    assign mod_ident = mod_pending & mod_enable_reg;

    // source vector assembly; pins polarity corrected on entry
    logic [NSRC-1:0] src_raw, src_evt, src_pending, src_ident;
    logic [NSRC-1:0] dst_ident [4];
    always_comb begin
        src_raw = periph_irq;
        src_raw[`CIC_BIT_PORT_MODULE_AGGREGATE] = |mod_ident;
        src_raw[`CIC_BIT_PIN_SOURCE_ZERO] = ext_irq_in[0] ^ ext_in_pol_reg[0];
        src_raw[`CIC_BIT_PIN_SOURCE_ONE] = ext_irq_in[1] ^ ext_in_pol_reg[1];
    end
    always_comb begin
        for (int i = 0; i < NSRC; i++) begin
            src_evt[i] = detect(src_raw[i], src_prev_reg[i], src_mode_lo_reg[i],
                                src_mode_hi_reg[i]);
        end
    end
    // nonlatch sources take the raw value for pending; the log still records their events
    assign src_pending = (src_nonlatch_reg & src_raw) | (~src_nonlatch_reg & src_log_reg);
    assign src_ident = src_pending & src_enable_reg;
    always_comb begin
        for (int d = 0; d < 4; d++) begin
            dst_ident[d] = src_ident & dst_mask_reg[d];
        end
    end

    // previous-value history for edge detection
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_prev_reg <= '0;
            mod_prev_reg <= '0;
        end else begin
            src_prev_reg <= src_raw;
            mod_prev_reg <= mod_raw;
        end
    end

    // source log: set and inject win over a software clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_log_reg <= '0;
        end else begin
            src_log_reg <= (src_log_reg & ~(wr_src_log ? reg_wdata[NSRC-1:0] : '0))
                | src_evt
                | (wr_src_inject ? reg_wdata[NSRC-1:0] : '0);
        end
    end

    // module log, same clear-by-one behaviour
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mod_log_reg <= '0;
        end else if (req.wr && req.addr == `CIC_MODULE_EVENT_LOG) begin
            mod_log_reg <= (mod_log_reg & ~reg_wdata[MODULES-1:0]) | mod_evt;
        end else begin
            mod_log_reg <= mod_log_reg | mod_evt;
        end
    end

    // source enable with atomic set and clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_enable_reg <= '0;
        end else if (wr_en_vec) begin
            src_enable_reg <= reg_wdata[NSRC-1:0];
        end else if (wr_en_clr) begin
            src_enable_reg <= src_enable_reg & ~reg_wdata[NSRC-1:0];
        end else if (wr_en_set) begin
            src_enable_reg <= src_enable_reg | reg_wdata[NSRC-1:0];
        end
    end

    // plain configuration registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_nonlatch_reg <= '0;
            src_mode_lo_reg <= '0;
            src_mode_hi_reg <= '0;
            for (int d = 0; d < 4; d++) begin
                dst_mask_reg[d] <= '0;
            end
            mod_pol_reg <= '0;
            mod_nonlatch_reg <= '0;
            mod_mode_lo_reg <= '0;
            mod_mode_hi_reg <= '0;
            mod_enable_reg <= '0;
            ext_in_pol_reg <= `CIC_RST_EXT_POL;
            ext_out_pol_reg <= `CIC_RST_EXT_POL;
            ext_drive_reg <= '0;
        end else if (req.wr) begin
            if (wr_src_nonlatch) src_nonlatch_reg <= reg_wdata[NSRC-1:0];
            if (wr_src_lo) src_mode_lo_reg <= reg_wdata[NSRC-1:0];
            if (wr_src_hi) src_mode_hi_reg <= reg_wdata[NSRC-1:0];
            for (int d = 0; d < 4; d++) begin
                if (req.addr == `CIC_DESTINATION_SOURCE_MASK + 8'(d)) begin
                    dst_mask_reg[d] <= reg_wdata[NSRC-1:0];
                end
            end
            case (req.addr)
                `CIC_MODULE_INPUT_POLARITY: mod_pol_reg <= reg_wdata[MODULES-1:0];
                `CIC_MODULE_NONLATCH_SELECT: mod_nonlatch_reg <= reg_wdata[MODULES-1:0];
                `CIC_MODULE_DETECT_MODE_LO: mod_mode_lo_reg <= reg_wdata[MODULES-1:0];
                `CIC_MODULE_DETECT_MODE_HI: mod_mode_hi_reg <= reg_wdata[MODULES-1:0];
                `CIC_MODULE_ENABLE_VECTOR: mod_enable_reg <= reg_wdata[MODULES-1:0];
                `CIC_EXT_INPUT_POLARITY: ext_in_pol_reg <= reg_wdata[1:0];
                `CIC_EXT_OUTPUT_POLARITY: ext_out_pol_reg <= reg_wdata[1:0];
                `CIC_EXT_OUTPUT_DRIVE_MODE: ext_drive_reg <= reg_wdata[1:0];
                default: ;
            endcase
        end
    end

    // destinations: OR of mapped identity, registered once in the output stage
    logic [3:0] dest_next;
    always_comb begin
        for (int d = 0; d < 4; d++) begin
            dest_next[d] = |dst_ident[d];
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_irq <= '0;
            ext_irq_out <= '0;
            ext_irq_oe <= '0;
        end else begin
            cpu_irq <= dest_next[1:0];
            for (int e = 0; e < 2; e++) begin
                // open drain where ext_drive_reg is set: drive only the low level, release the pin otherwise; push-pull where it is clear
                ext_irq_out[e] <= dest_next[2+e] ^ ext_out_pol_reg[e];
                ext_irq_oe[e] <= ext_drive_reg[e] ?
                    (dest_next[2+e] ^ ext_out_pol_reg[e]) == 1'b0 : 1'b1;
            end
        end
    end

    // read port, data in the cycle after the strobe
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (req.rd) begin
            reg_rdata <= '0;
            case (req.addr)
                `CIC_SOURCE_RAW_VECTOR: reg_rdata <= 32'(src_raw);
                `CIC_SOURCE_NONLATCH_SELECT: reg_rdata <= 32'(src_nonlatch_reg);
                `CIC_SOURCE_DETECT_MODE_LO: reg_rdata <= 32'(src_mode_lo_reg);
                `CIC_SOURCE_DETECT_MODE_HI: reg_rdata <= 32'(src_mode_hi_reg);
                `CIC_SOURCE_EVENT_LOG: reg_rdata <= 32'(src_log_reg);
                `CIC_SOURCE_ENABLE_VECTOR: reg_rdata <= 32'(src_enable_reg);
                `CIC_SOURCE_PENDING_IDENTITY: reg_rdata <= 32'(src_ident);
                `CIC_DESTINATION_SOURCE_MASK: reg_rdata <= 32'(dst_mask_reg[0]);
                8'h11: reg_rdata <= 32'(dst_mask_reg[1]);
                8'h12: reg_rdata <= 32'(dst_mask_reg[2]);
                8'h13: reg_rdata <= 32'(dst_mask_reg[3]);
                `CIC_DESTINATION_PENDING_IDENTITY: reg_rdata <= 32'(dst_ident[0]);
                8'h15: reg_rdata <= 32'(dst_ident[1]);
                8'h16: reg_rdata <= 32'(dst_ident[2]);
                8'h17: reg_rdata <= 32'(dst_ident[3]);
                `CIC_MODULE_INPUT_POLARITY: reg_rdata <= 32'(mod_pol_reg);
                `CIC_MODULE_RAW_VECTOR: reg_rdata <= 32'(mod_raw);
                `CIC_MODULE_NONLATCH_SELECT: reg_rdata <= 32'(mod_nonlatch_reg);
                `CIC_MODULE_DETECT_MODE_LO: reg_rdata <= 32'(mod_mode_lo_reg);
                `CIC_MODULE_DETECT_MODE_HI: reg_rdata <= 32'(mod_mode_hi_reg);
                `CIC_MODULE_EVENT_LOG: reg_rdata <= 32'(mod_log_reg);
                `CIC_MODULE_ENABLE_VECTOR: reg_rdata <= 32'(mod_enable_reg);
                `CIC_MODULE_PENDING_IDENTITY: reg_rdata <= 32'(mod_ident);
                `CIC_EXT_INPUT_POLARITY: reg_rdata <= 32'(ext_in_pol_reg);
                `CIC_EXT_OUTPUT_POLARITY: reg_rdata <= 32'(ext_out_pol_reg);
                `CIC_EXT_OUTPUT_DRIVE_MODE: reg_rdata <= 32'(ext_drive_reg);
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // checks
    AST_ENA_CLR: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_en_clr |=> src_enable_reg == ($past(src_enable_reg) & ~$past(reg_wdata[NSRC-1:0])))
        else $error("enable clear wrong");
    AST_ENA_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_en_set |=> src_enable_reg == ($past(src_enable_reg) | $past(reg_wdata[NSRC-1:0])))
        else $error("enable set wrong");
    AST_INJECT: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_src_inject |=> (src_log_reg & $past(reg_wdata[NSRC-1:0])) == $past(reg_wdata[NSRC-1:0]))
        else $error("inject lost");
    AST_LEVEL_RESET: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!src_mode_lo_reg[3] && !src_mode_hi_reg[3] && src_raw[3]) |=> src_log_reg[3])
        else $error("level source not relogged");
    AST_NONLATCH: assert property (@(posedge core_clk) disable iff (!rst_n)
        src_nonlatch_reg[4] |-> src_pending[4] == src_raw[4])
        else $error("nonlatch mismatch");
    AST_CPU_OUT: assert property (@(posedge core_clk) disable iff (!rst_n)
        |dst_ident[0] |=> cpu_irq[0])
        else $error("cpu dest not raised");
    AST_DEST_QUIET: assert property (@(posedge core_clk) disable iff (!rst_n)
        dst_mask_reg[1] == '0 |=> !cpu_irq[1])
        else $error("unmapped dest raised");
    AST_AGGREGATE: assert property (@(posedge core_clk) disable iff (!rst_n)
        src_raw[0] == |(mod_pending & mod_enable_reg))
        else $error("aggregate mismatch");
    AST_READ_RAW: assert property (@(posedge core_clk) disable iff (!rst_n)
        (req.rd && req.addr == `CIC_SOURCE_RAW_VECTOR) |=> reg_rdata == 32'($past(src_raw)))
        else $error("raw read wrong");
endmodule
`default_nettype wire

// File: tb/cic_far_end.sv
// Purpose: far side of the controller: peripheral, port-module and pin sources, pin outputs
// Assumes: source levels requested by the bench, taken on the next rising edge
// Notes: outputs meet a board pull-up, so a released pin reads high
`timescale 1ns/1ps
`default_nettype none

module cic_far_end (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // levels requested by the bench
    input wire logic [26:0] periph_set,
    input wire logic [7:0] module_set,
    input wire logic [1:0] pin_set,
    // lines into the controller
    output logic [26:0] periph_irq,
    output logic [7:0] port_module_irq,
    output logic [1:0] ext_irq_in,
    // pins out of the controller
    input wire logic [1:0] ext_irq_out,
    input wire logic [1:0] ext_irq_oe,
    output logic [1:0] pin_level
);
    // sources launch from a flop, like the real blocks; pins idle high (inactive)
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            periph_irq <= 27'h0000000;
            port_module_irq <= 8'h00;
            ext_irq_in <= 2'h3;
        end else begin
            periph_irq <= periph_set;
            port_module_irq <= module_set;
            ext_irq_in <= pin_set;
        end
    end

    // pull-up wins wherever the controller lets go of a pin
    assign pin_level = (ext_irq_oe & ext_irq_out) | ~ext_irq_oe;
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Purpose: self-checking bench of the interrupt controller
// Assumes: register port with read data one cycle after the strobe
// Notes: a settle of four cycles covers far-end flop plus log and output flops
`timescale 1ns/1ps
`default_nettype none
`include "cic_regs.svh"

module testbench;
    import cic_pkg::*;

    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    cic_req_s bus_req = '0;
    logic [31:0] reg_rdata;
    logic [31:0] rd_val;
    logic [26:0] periph_irq;
    logic [26:0] periph_set = 27'h0000000;
    logic [7:0] port_module_irq;
    logic [7:0] module_set = 8'h00;
    logic [1:0] ext_irq_in;
    logic [1:0] pin_set = 2'h3;
    logic [1:0] cpu_irq;
    logic [1:0] ext_irq_out;
    logic [1:0] ext_irq_oe;
    logic [1:0] pin_level;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;

    // 40 MHz core clock
    always #12.5 core_clk = ~core_clk;

    cic_ctrl #(.MODULES(8)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
        .reg_addr(bus_req.addr), .reg_wdata(bus_req.wdata), .reg_wr(bus_req.wr),
        .reg_rd(bus_req.rd), .reg_rdata(reg_rdata), .periph_irq(periph_irq),
        .port_module_irq(port_module_irq), .ext_irq_in(ext_irq_in), .cpu_irq(cpu_irq),
        .ext_irq_out(ext_irq_out), .ext_irq_oe(ext_irq_oe));

    cic_far_end far_u (.core_clk(core_clk), .rst_n(rst_n), .periph_set(periph_set),
        .module_set(module_set), .pin_set(pin_set), .periph_irq(periph_irq),
        .port_module_irq(port_module_irq), .ext_irq_in(ext_irq_in),
        .ext_irq_out(ext_irq_out), .ext_irq_oe(ext_irq_oe), .pin_level(pin_level));

    task automatic summarize;
        if (fails == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // cut a hang short; the whole run needs a few hundred cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            summarize();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
        chk(what, rd_val, exp);
    endtask

    task automatic drive(input logic [26:0] p, input logic [7:0] m, input logic [1:0] pins);
        @(posedge core_clk);
        periph_set <= p;
        module_set <= m;
        pin_set <= pins;
        repeat (4) @(posedge core_clk);
        #1;
    endtask

    task automatic t_reset;
        rchk("in pol", `CIC_EXT_INPUT_POLARITY, 32'h0000_0003);
        rchk("out pol", `CIC_EXT_OUTPUT_POLARITY, 32'h0000_0003);
        rchk("drive", `CIC_EXT_OUTPUT_DRIVE_MODE, 32'h0000_0000);
        rchk("mask0", `CIC_DESTINATION_SOURCE_MASK, 32'h0000_0000);
        chk("cpu idle", {30'h0, cpu_irq}, 32'h0000_0000);
        chk("pins idle", {30'h0, ext_irq_out}, 32'h0000_0003);
        chk("oe idle", {30'h0, ext_irq_oe}, 32'h0000_0003);
        wr(8'h3F, 32'hFFFF_FFFF);
        rchk("unmapped", 8'h3F, 32'h0000_0000);
    endtask

    task automatic t_enable;
        wr(`CIC_SOURCE_ENABLE_VECTOR, 32'h0000_00F0);
        wr(`CIC_SOURCE_ENABLE_SET, 32'h0000_0001);
        rchk("en set", `CIC_SOURCE_ENABLE_VECTOR, 32'h0000_00F1);
        wr(`CIC_SOURCE_ENABLE_CLEAR, 32'h0000_0010);
        rchk("en clr", `CIC_SOURCE_ENABLE_VECTOR, 32'h0000_00E1);
        wr(`CIC_SOURCE_ENABLE_VECTOR, 32'h0000_0000);
    endtask

    // level source on bit 3 with bit 26 driven alongside, neither enabled nor mapped
    task automatic t_level;
        drive(27'h4000008, 8'h00, 2'h3);
        rchk("raw", `CIC_SOURCE_RAW_VECTOR, 32'h0400_0008);
        rchk("log", `CIC_SOURCE_EVENT_LOG, 32'h0400_0008);
        rchk("ident off", `CIC_SOURCE_PENDING_IDENTITY, 32'h0000_0000);
        wr(`CIC_DESTINATION_SOURCE_MASK, 32'h0000_0008);
        wr(`CIC_SOURCE_ENABLE_SET, 32'h0000_0008);
        drive(27'h4000008, 8'h00, 2'h3);
        chk("cpu0", {30'h0, cpu_irq}, 32'h0000_0001);
        rchk("ident", `CIC_SOURCE_PENDING_IDENTITY, 32'h0000_0008);
        rchk("dst0 id", `CIC_DESTINATION_PENDING_IDENTITY, 32'h0000_0008);
        rchk("dst1 id", `CIC_DESTINATION_PENDING_IDENTITY + 8'h01, 32'h0000_0000);
        wr(`CIC_SOURCE_EVENT_LOG, 32'h0000_0008);
        rchk("relog", `CIC_SOURCE_EVENT_LOG, 32'h0400_0008);
        drive(27'h0000000, 8'h00, 2'h3);
        wr(`CIC_SOURCE_EVENT_LOG, 32'h0000_0000);
        rchk("sticky", `CIC_SOURCE_EVENT_LOG, 32'h0400_0008);
        chk("cpu0 held", {30'h0, cpu_irq}, 32'h0000_0001);
        wr(`CIC_SOURCE_EVENT_LOG, 32'h0400_0008);
        rchk("cleared", `CIC_SOURCE_EVENT_LOG, 32'h0000_0000);
        drive(27'h0000000, 8'h00, 2'h3);
        chk("cpu0 off", {30'h0, cpu_irq}, 32'h0000_0000);
        wr(`CIC_SOURCE_ENABLE_CLEAR, 32'h0000_0008);
        wr(`CIC_DESTINATION_SOURCE_MASK, 32'h0000_0000);
    endtask

    // modes 1..3 on bit 4: any edge, falling, rising
    task automatic t_edges;
        for (int m = 1; m <= 3; m++) begin
            wr(`CIC_SOURCE_DETECT_MODE_LO, (m != 2) ? 32'h0000_0010 : 32'h0000_0000);
            wr(`CIC_SOURCE_DETECT_MODE_HI, (m > 1) ? 32'h0000_0010 : 32'h0000_0000);
            wr(`CIC_SOURCE_EVENT_LOG, 32'h0000_0010);
            drive(27'h0000010, 8'h00, 2'h3);
            wr(`CIC_SOURCE_EVENT_LOG, 32'h0000_0000);
            rchk("rise", `CIC_SOURCE_EVENT_LOG, (m != 2) ? 32'h10 : 32'h0);
            wr(`CIC_SOURCE_EVENT_LOG, 32'h0000_0010);
            rchk("no relog", `CIC_SOURCE_EVENT_LOG, 32'h0000_0000);
            drive(27'h0000000, 8'h00, 2'h3);
            rchk("fall", `CIC_SOURCE_EVENT_LOG, (m != 3) ? 32'h10 : 32'h0);
            wr(`CIC_SOURCE_EVENT_LOG, 32'h0000_0010);
        end
        wr(`CIC_SOURCE_DETECT_MODE_LO, 32'h0000_0000);
        wr(`CIC_SOURCE_DETECT_MODE_HI, 32'h0000_0000);
    endtask

    // bit 5 on destination 1, raw value instead of the log
    task automatic t_bypass;
        wr(`CIC_SOURCE_NONLATCH_SELECT, 32'h0000_0020);
        wr(`CIC_SOURCE_ENABLE_SET, 32'h0000_0020);
        wr(`CIC_DESTINATION_SOURCE_MASK + 8'h01, 32'h0000_0020);
        drive(27'h0000020, 8'h00, 2'h3);
        chk("cpu1 on", {30'h0, cpu_irq}, 32'h0000_0002);
        drive(27'h0000000, 8'h00, 2'h3);
        chk("cpu1 off", {30'h0, cpu_irq}, 32'h0000_0000);
        wr(`CIC_SOURCE_EVENT_INJECT, 32'h0000_0800);
        rchk("inject", `CIC_SOURCE_EVENT_LOG, 32'h0000_0820);
        wr(`CIC_SOURCE_EVENT_LOG, 32'h0000_0820);
        wr(`CIC_SOURCE_NONLATCH_SELECT, 32'h0000_0000);
        wr(`CIC_SOURCE_ENABLE_CLEAR, 32'h0000_0020);
        wr(`CIC_DESTINATION_SOURCE_MASK + 8'h01, 32'h0000_0000);
    endtask

    task automatic t_modules;
        wr(`CIC_MODULE_INPUT_POLARITY, 32'h0000_0000);
        wr(`CIC_MODULE_EVENT_LOG, 32'h0000_00FF);
        drive(27'h0000000, 8'h04, 2'h3);
        rchk("mod raw", `CIC_MODULE_RAW_VECTOR, 32'h0000_0004);
        rchk("mod log", `CIC_MODULE_EVENT_LOG, 32'h0000_0004);
        rchk("mod id off", `CIC_MODULE_PENDING_IDENTITY, 32'h0000_0000);
        wr(`CIC_MODULE_ENABLE_VECTOR, 32'h0000_0004);
        wr(`CIC_SOURCE_ENABLE_SET, 32'h0000_0001);
        wr(`CIC_DESTINATION_SOURCE_MASK, 32'h0000_0001);
        drive(27'h0000000, 8'h04, 2'h3);
        rchk("mod id", `CIC_MODULE_PENDING_IDENTITY, 32'h0000_0004);
        rchk("aggregate", `CIC_SOURCE_RAW_VECTOR, 32'h0000_0001);
        chk("cpu0 agg", {30'h0, cpu_irq}, 32'h0000_0001);
        wr(`CIC_MODULE_INPUT_POLARITY, 32'h0000_0004);
        rchk("mod pol", `CIC_MODULE_RAW_VECTOR, 32'h0000_0000);
        wr(`CIC_MODULE_INPUT_POLARITY, 32'h0000_0000);
        wr(`CIC_MODULE_ENABLE_VECTOR, 32'h0000_0000);
        drive(27'h0000000, 8'h00, 2'h3);
        wr(`CIC_MODULE_EVENT_LOG, 32'h0000_00FF);
        wr(`CIC_SOURCE_EVENT_LOG, 32'h0000_0001);
        rchk("agg clear", `CIC_SOURCE_EVENT_LOG, 32'h0000_0000);
        wr(`CIC_SOURCE_ENABLE_CLEAR, 32'h0000_0001);
        wr(`CIC_DESTINATION_SOURCE_MASK, 32'h0000_0000);
    endtask

    // pin inputs, then destinations 2 and 3 on the pins
    task automatic t_pins;
        drive(27'h0000000, 8'h00, 2'h2);
        rchk("pin low act", `CIC_SOURCE_RAW_VECTOR, 32'h0000_0002);
        wr(`CIC_EXT_INPUT_POLARITY, 32'h0000_0000);
        rchk("pin high act", `CIC_SOURCE_RAW_VECTOR, 32'h0000_0004);
        wr(`CIC_EXT_INPUT_POLARITY, 32'h0000_0003);
        drive(27'h0000000, 8'h00, 2'h3);
        wr(`CIC_SOURCE_EVENT_LOG, 32'h0000_0006);
        wr(`CIC_SOURCE_EVENT_INJECT, 32'h0000_1000);
        wr(`CIC_SOURCE_ENABLE_SET, 32'h0000_1000);
        wr(`CIC_DESTINATION_SOURCE_MASK + 8'h02, 32'h0000_1000);
        drive(27'h0000000, 8'h00, 2'h3);
        chk("out inv", {30'h0, ext_irq_out}, 32'h0000_0002);
        chk("oe push", {30'h0, ext_irq_oe}, 32'h0000_0003);
        wr(`CIC_EXT_OUTPUT_POLARITY, 32'h0000_0000);
        wr(`CIC_EXT_OUTPUT_DRIVE_MODE, 32'h0000_0003);
        drive(27'h0000000, 8'h00, 2'h3);
        chk("out true", {30'h0, ext_irq_out}, 32'h0000_0001);
        chk("oe opendrain", {30'h0, ext_irq_oe}, 32'h0000_0002);
        chk("pin wire", {30'h0, pin_level}, 32'h0000_0001);
        wr(`CIC_DESTINATION_SOURCE_MASK + 8'h03, 32'h0000_1000);
        drive(27'h0000000, 8'h00, 2'h3);
        chk("both out", {30'h0, ext_irq_out}, 32'h0000_0003);
        chk("both oe", {30'h0, ext_irq_oe}, 32'h0000_0000);
        chk("cpu clear", {30'h0, cpu_irq}, 32'h0000_0000);
    endtask

    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_reset();
        t_enable();
        t_level();
        t_edges();
        t_bypass();
        t_modules();
        t_pins();
        summarize();
    end
endmodule
`default_nettype wire
